// *** rtl/rds_down_sampler.sv ***
// rate down sampler: one value kept from each frame of input samples
//
// Functional notes
// - the ratio of input samples per frame is an integer of at least two, smaller values are refused.
// - the output sample period is the input sample period times the ratio.
// - a setting picks whether the first or the last value of each frame is kept.
// - with latency above zero the kept value drives the output and stays stable until the next capture.
// - the zero latency form is only allowed when the first value is kept.
// - in the zero latency form the first sample of a frame passes through a mux to the output in its slot.
// - in the zero latency form a register takes the first sample and the mux selects it from the second slot on.
// - a one bit register shifts the output-rate enable to the start of the output period.
// - with latency above zero the path is fully registered, shaped by the first or last choice.
// - in the registered first form a register on the shifted enable takes the input at frame start.
// - in the registered first form a second register copies the first at the end of the output period.
// - in the last form one register takes the input at frame end on the output-rate enable.
// - in the last form each captured value shows on the output through the following frame.
`timescale 1ns/1ps
module rds_down_sampler #(
   parameter int WIDTH = rds_pkg::RDS_WIDTH_DEF,
   parameter int RATIO = rds_pkg::RDS_RATIO_DEF,
   parameter int LATENCY = rds_pkg::RDS_LATENCY_DEF,
   parameter rds_pkg::rds_mode_t MODE = rds_pkg::RDS_FIRST,
   parameter int DEPTH = rds_pkg::RDS_FIFO_DEPTH
)(
   input wire logic clock,
   input wire logic rstn,
   input wire logic src_ce,
   input wire logic dest_ce,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout,
   output logic dout_strobe,
   output logic frame_err,
   output logic in_ready,
   output logic q_valid,
   input wire logic q_ready,
   output logic [WIDTH-1:0] q_data
);
   import rds_pkg::*;

   localparam int CW = $clog2(RATIO + 1);
   localparam logic [CW-1:0] LAST_SLOT = CW'(RATIO - 1);
   localparam logic ZERO_LAT = (LATENCY == 0);

   typedef struct packed {
      logic first_slot;
      logic [WIDTH-1:0] cap;
      logic [WIDTH-1:0] held;
      logic [CW-1:0] slot;
      logic err;
      logic strobe;
   } rds_state_t;

   rds_state_t st;
   rds_state_t next_st;
   logic go_src;
   logic go_dest;
   logic [WIDTH-1:0] push_data;

   // both enables come from logic on this clock; a full fifo stalls them
   assign go_src = src_ce & in_ready;
   assign go_dest = dest_ce & in_ready;

   // value that becomes the new output sample at this boundary
   assign push_data = (MODE == RDS_LAST) ? din : st.cap;

   always_comb begin
      next_st = st;
      next_st.strobe = go_dest;
      if (go_src) begin
         // alignment bit marks the slot that follows a frame end
         next_st.first_slot = go_dest;
         if (go_dest) begin
            next_st.slot = '0;
         end else if (st.slot != LAST_SLOT) begin
            next_st.slot = st.slot + 1'b1;
         end
      end
      // frame end that does not land on the last slot of the frame
      if (go_dest && (!go_src || st.slot != LAST_SLOT)) begin
         next_st.err = 1'b1;
      end
      if (MODE == RDS_FIRST) begin
         if (go_src && st.first_slot) begin
            next_st.cap = din;
         end
         if (!ZERO_LAT && go_dest) begin
            next_st.held = st.cap;
         end
      end else if (go_dest) begin
         next_st.cap = din;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
         st.first_slot <= RDS_FIRST_SLOT_RST;
         st.err <= RDS_ERR_RST;
         st.strobe <= RDS_STROBE_RST;
      end else begin
         st <= next_st;
      end
   end

   // output selection per implementation form
   always_comb begin
      if (ZERO_LAT) begin
         dout = st.first_slot ? din : st.cap;
      end else if (MODE == RDS_FIRST) begin
         dout = st.held;
      end else begin
         dout = st.cap;
      end
   end

   assign dout_strobe = st.strobe;
   assign frame_err = st.err;

   rds_fifo #(
      .WIDTH(WIDTH),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clock(clock),
      .rstn(rstn),
      .in_valid(go_dest),
      .in_ready(in_ready),
      .in_data(push_data),
      .out_valid(q_valid),
      .out_ready(q_ready),
      .out_data(q_data)
   );

   // checks
   property p_ratio_min;
      @(posedge clock) disable iff (!rstn) RATIO >= RDS_RATIO_MIN;
   endproperty
   a_ratio_min: assert property (p_ratio_min) else $error("ratio below two");

   property p_zero_lat_first;
      @(posedge clock) disable iff (!rstn) !ZERO_LAT || MODE == RDS_FIRST;
   endproperty
   a_zero_lat_first: assert property (p_zero_lat_first) else $error("zero latency needs first mode");

   property p_period;
      @(posedge clock) disable iff (!rstn)
         go_src && !go_dest && st.slot != LAST_SLOT |=> !st.err || $past(st.err);
   endproperty
   a_period: assert property (p_period) else $error("error raised inside a frame");

   property p_align;
      @(posedge clock) disable iff (!rstn) go_src |=> st.first_slot == $past(go_dest);
   endproperty
   a_align: assert property (p_align) else $error("alignment bit wrong");

   property p_zero_pass;
      @(posedge clock) disable iff (!rstn) ZERO_LAT && st.first_slot |-> dout == din;
   endproperty
   a_zero_pass: assert property (p_zero_pass) else $error("first slot not passed through");

   property p_zero_hold;
      @(posedge clock) disable iff (!rstn)
         ZERO_LAT && go_src && st.first_slot && !go_dest |=> !st.first_slot && dout == $past(din);
   endproperty
   a_zero_hold: assert property (p_zero_hold) else $error("first sample not held");

   property p_first_cap;
      @(posedge clock) disable iff (!rstn)
         !ZERO_LAT && MODE == RDS_FIRST && go_src && st.first_slot |=> st.cap == $past(din);
   endproperty
   a_first_cap: assert property (p_first_cap) else $error("frame start not captured");

   property p_first_out;
      @(posedge clock) disable iff (!rstn)
         !ZERO_LAT && MODE == RDS_FIRST && go_dest |=> dout == $past(st.cap) && dout_strobe;
   endproperty
   a_first_out: assert property (p_first_out) else $error("second register not loaded");

   property p_last_cap;
      @(posedge clock) disable iff (!rstn) MODE == RDS_LAST && go_dest |=> dout == $past(din);
   endproperty
   a_last_cap: assert property (p_last_cap) else $error("frame end not captured");

   property p_stable;
      @(posedge clock) disable iff (!rstn) !ZERO_LAT && !go_dest |=> $stable(dout);
   endproperty
   a_stable: assert property (p_stable) else $error("output moved between captures");

   property p_reset_zero;
      @(posedge clock) !rstn |-> dout == '0 && !dout_strobe && !st.first_slot;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("output not zero in reset");

   property p_strobe_set;
      @(posedge clock) disable iff (!rstn)
         go_dest |=> dout_strobe;
   endproperty
   a_strobe_set: assert property (p_strobe_set) else $error("no strobe after frame end");

   property p_strobe_clear;
      @(posedge clock) disable iff (!rstn)
         !go_dest |=> !dout_strobe;
   endproperty
   a_strobe_clear: assert property (p_strobe_clear) else $error("strobe without frame end");

   property p_slot_range;
      @(posedge clock) disable iff (!rstn)
         st.slot <= LAST_SLOT;
   endproperty
   a_slot_range: assert property (p_slot_range) else $error("slot count beyond frame");

   property p_slot_wrap;
      @(posedge clock) disable iff (!rstn)
         go_src && go_dest |=> st.slot == '0;
   endproperty
   a_slot_wrap: assert property (p_slot_wrap) else $error("slot count not restarted");

   property p_slot_step;
      @(posedge clock) disable iff (!rstn)
         go_src && !go_dest && st.slot != LAST_SLOT |=> st.slot == $past(st.slot) + 1'b1;
   endproperty
   a_slot_step: assert property (p_slot_step) else $error("slot count did not advance");

   property p_idle_hold;
      @(posedge clock) disable iff (!rstn)
         !go_src |=> $stable(st.slot) && $stable(st.first_slot);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("slot state moved without input enable");

   property p_stall;
      @(posedge clock) disable iff (!rstn)
         !in_ready |=> $stable(st.cap) && $stable(st.held) && $stable(st.slot);
   endproperty
   a_stall: assert property (p_stall) else $error("state moved while stalled");

   property p_err_sticky;
      @(posedge clock) disable iff (!rstn)
         st.err |=> st.err;
   endproperty
   a_err_sticky: assert property (p_err_sticky) else $error("frame error cleared");

   property p_err_set;
      @(posedge clock) disable iff (!rstn)
         go_dest && (!go_src || st.slot != LAST_SLOT) |=> st.err;
   endproperty
   a_err_set: assert property (p_err_set) else $error("misplaced frame end not flagged");

   property p_err_clean;
      @(posedge clock) disable iff (!rstn)
         go_dest && go_src && st.slot == LAST_SLOT && !st.err |=> !st.err;
   endproperty
   a_err_clean: assert property (p_err_clean) else $error("aligned frame end flagged");

   property p_first_idle;
      @(posedge clock) disable iff (!rstn)
         MODE == RDS_FIRST && !(go_src && st.first_slot) |=> $stable(st.cap);
   endproperty
   a_first_idle: assert property (p_first_idle) else $error("first register moved off frame start");

   property p_held_idle;
      @(posedge clock) disable iff (!rstn)
         !ZERO_LAT && MODE == RDS_FIRST && !go_dest |=> $stable(st.held);
   endproperty
   a_held_idle: assert property (p_held_idle) else $error("second register moved off frame end");

   property p_last_idle;
      @(posedge clock) disable iff (!rstn)
         MODE == RDS_LAST && !go_dest |=> $stable(st.cap);
   endproperty
   a_last_idle: assert property (p_last_idle) else $error("last register moved off frame end");

   property p_zero_reg;
      @(posedge clock) disable iff (!rstn)
         ZERO_LAT && !st.first_slot |-> dout == st.cap;
   endproperty
   a_zero_reg: assert property (p_zero_reg) else $error("mux not on register after first slot");

   property p_zero_keep;
      @(posedge clock) disable iff (!rstn)
         ZERO_LAT && !st.first_slot && !go_dest |=> $stable(dout);
   endproperty
   a_zero_keep: assert property (p_zero_keep) else $error("zero latency output moved in frame");

   property p_q_hold;
      @(posedge clock) disable iff (!rstn)
         q_valid && !q_ready |=> q_valid && $stable(q_data);
   endproperty
   a_q_hold: assert property (p_q_hold) else $error("queued word dropped while waiting");
endmodule

// *** rtl/rds_fifo.sv ***
// sample fifo with valid and ready on both sides
`timescale 1ns/1ps
module rds_fifo #(
   parameter int WIDTH = rds_pkg::RDS_WIDTH_DEF,
   parameter int DEPTH = rds_pkg::RDS_FIFO_DEPTH
)(
   input wire logic clock,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   import rds_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] cnt;
      logic ovalid;
   } rds_fifo_state_t;

   rds_fifo_state_t st;
   rds_fifo_state_t next_st;
   logic push;
   logic pop;

   // depth must be a power of two so the pointers wrap by themselves
   assign in_ready = (st.cnt != FULL_CNT);
   assign push = in_valid & in_ready;
   assign pop = (st.cnt != '0) & (!st.ovalid | out_ready);
   assign out_valid = st.ovalid;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.wptr = st.wptr + 1'b1;
      end
      if (pop) begin
         next_st.rptr = st.rptr + 1'b1;
      end
      next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (pop) begin
         next_st.ovalid = 1'b1;
      end else if (out_ready) begin
         next_st.ovalid = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   rds_mem #(
      .WIDTH(WIDTH),
      .DEPTH(DEPTH)
   ) u_mem (
      .clock(clock),
      .rstn(rstn),
      .wr_en(push),
      .wr_addr(st.wptr),
      .wr_data(in_data),
      .rd_en(pop),
      .rd_addr(st.rptr),
      .rd_data(out_data)
   );
endmodule

// *** rtl/rds_mem.sv ***
// simple dual port sample memory with registered read data
`timescale 1ns/1ps
module rds_mem #(
   parameter int WIDTH = rds_pkg::RDS_WIDTH_DEF,
   parameter int DEPTH = rds_pkg::RDS_FIFO_DEPTH
)(
   input wire logic clock,
   input wire logic rstn,
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   import rds_pkg::*;

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // read word held until the next read
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rd_data <= '0;
      end else if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// *** shared/rds_pkg.sv ***
// constants and types shared by the rate down sampler files
package rds_pkg;
   localparam int RDS_WIDTH_DEF = 16;
   localparam int RDS_RATIO_DEF = 4;
   localparam int RDS_RATIO_MIN = 2;
   localparam int RDS_LATENCY_DEF = 1;
   localparam int RDS_FIFO_DEPTH = 32;
   localparam int RDS_CLK_PERIOD_NS = 20;
   localparam logic RDS_FIRST_SLOT_RST = 1'b0;
   localparam logic RDS_ERR_RST = 1'b0;
   localparam logic RDS_STROBE_RST = 1'b0;

   typedef enum logic {
      RDS_FIRST = 1'b0,
      RDS_LAST = 1'b1
   } rds_mode_t;
endpackage

// *** tb/rds_down_sampler_test.sv ***
// self-checking bench for the rate down sampler in its last, first and zero latency forms
`timescale 1ns/1ps
module rds_down_sampler_test;
   import rds_pkg::*;
   localparam int RATIO = 4;
   logic clock;
   logic rstn;
   logic q_ready;
   logic src_ce;
   logic dest_ce;
   logic [15:0] din;
   logic [15:0] dout;
   logic [15:0] q_data;
   logic dout_strobe;
   logic frame_err;
   logic in_ready;
   logic q_valid;
   logic [15:0] dout_first;
   logic [15:0] dout_zero;
   logic [15:0] q_first;
   logic [15:0] q_zero;
   logic q_valid_first;
   logic q_valid_zero;
   logic [15:0] got[$];
   logic [15:0] got_first[$];
   logic [15:0] got_zero[$];
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int strobes = 0;

   rds_down_sampler #(.RATIO(RATIO), .LATENCY(1), .MODE(RDS_LAST)) DUT (
      .clock(clock),
      .rstn(rstn),
      .src_ce(src_ce),
      .dest_ce(dest_ce),
      .din(din),
      .dout(dout),
      .dout_strobe(dout_strobe),
      .frame_err(frame_err),
      .in_ready(in_ready),
      .q_valid(q_valid),
      .q_ready(q_ready),
      .q_data(q_data)
   );

   rds_down_sampler #(.RATIO(RATIO), .LATENCY(1), .MODE(RDS_FIRST)) dut_first (
      .clock(clock),
      .rstn(rstn),
      .src_ce(src_ce),
      .dest_ce(dest_ce),
      .din(din),
      .dout(dout_first),
      .dout_strobe(),
      .frame_err(),
      .in_ready(),
      .q_valid(q_valid_first),
      .q_ready(q_ready),
      .q_data(q_first)
   );

   rds_down_sampler #(.RATIO(RATIO), .LATENCY(0), .MODE(RDS_FIRST)) dut_zero (
      .clock(clock),
      .rstn(rstn),
      .src_ce(src_ce),
      .dest_ce(dest_ce),
      .din(din),
      .dout(dout_zero),
      .dout_strobe(),
      .frame_err(),
      .in_ready(),
      .q_valid(q_valid_zero),
      .q_ready(q_ready),
      .q_data(q_zero)
   );

   rds_src #(.RATIO(RATIO)) src (
      .clock(clock),
      .in_ready(in_ready),
      .src_ce(src_ce),
      .dest_ce(dest_ce),
      .din(din)
   );

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // downstream sink, strobe counter and hang limit
   always @(posedge clock) begin
      cycles++;
      if (q_valid === 1'b1 && q_ready === 1'b1) got.push_back(q_data);
      if (q_valid_first === 1'b1 && q_ready === 1'b1) got_first.push_back(q_first);
      if (q_valid_zero === 1'b1 && q_ready === 1'b1) got_zero.push_back(q_zero);
      if (dout_strobe === 1'b1) strobes++;
      if (cycles == 2000) begin
         err_count++;
         $display("[FAIL] %0t timeout", $time);
         end_sim();
      end
   end

   task automatic check(input logic [15:0] act, input logic [15:0] exp, input string msg);
      n_compared++;
      if (act !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask

   // first forms keep sample 0; the frame right after reset has no start mark and keeps zero
   function automatic logic [15:0] exp_first(input int f);
      return (f == 1) ? 16'h0000 : {8'(f), 8'h00};
   endfunction

   // words popped from each fifo must be the kept sample of each frame, in order
   task automatic check_q(input int first, input int last);
      check(16'(got.size()), 16'(last - first + 1), "fifo word count");
      check(16'(got_first.size()), 16'(last - first + 1), "first form word count");
      check(16'(got_zero.size()), 16'(last - first + 1), "zero latency word count");
      for (int f = first; f <= last && got.size() > 0; f++) check(got.pop_front(), {8'(f), 8'h03}, "fifo word");
      for (int f = first; f <= last && got_first.size() > 0 && got_zero.size() > 0; f++) begin
         check(got_first.pop_front(), exp_first(f), "first form word");
         check(got_zero.pop_front(), exp_first(f), "zero latency word");
      end
   endtask

   task automatic t_reset();
      @(negedge clock);
      check(dout, 16'h0000, "dout in reset");
      check(16'(q_valid), 16'h0000, "q_valid in reset");
      check(16'(frame_err), 16'h0000, "frame_err in reset");
      check(16'(in_ready), 16'h0001, "in_ready in reset");
   endtask

   task automatic t_stream();
      int s0;
      s0 = strobes;
      q_ready <= 1'b1;
      for (int f = 1; f <= 3; f++) begin
         src.send(8'(f), RATIO - 1);
         @(negedge clock);
         check(dout, {8'(f), 8'h03}, "last sample kept");
         check(dout_first, exp_first(f), "first sample kept");
         check(dout_zero, din, "zero latency passes the first slot");
      end
      repeat (10) @(negedge clock);
      check(dout, 16'h0303, "dout held");
      check(dout_first, 16'h0300, "first form held");
      check(16'(strobes - s0), 16'h0003, "one strobe per frame");
      check_q(1, 3);
   endtask

   task automatic t_full();
      @(posedge clock);
      q_ready <= 1'b0;
      for (int f = 16; f <= 48; f++) src.send(8'(f), RATIO - 1);
      @(negedge clock);
      check(16'(in_ready), 16'h0000, "fifo full stalls input");
      @(posedge clock);
      q_ready <= 1'b1;
      repeat (80) @(posedge clock);
      check_q(16, 48);
   endtask

   task automatic t_err();
      src.send(8'h60, 1);
      @(negedge clock);
      check(16'(frame_err), 16'h0001, "misplaced frame end flagged");
      repeat (6) @(negedge clock);
      check(16'(frame_err), 16'h0001, "frame_err sticky");
   endtask

   task automatic end_sim();
      $display("errors %0d compared %0d", err_count, n_compared);
      if (err_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      rstn = 1'b0;
      q_ready = 1'b0;
      repeat (12) @(posedge clock);
      t_reset();
      @(posedge clock);
      rstn <= 1'b1;
      t_stream();
      t_full();
      t_err();
      end_sim();
   end
endmodule

// *** tb/rds_src.sv ***
// upstream sample source model that feeds frames into the down sampler
`timescale 1ns/1ps
module rds_src #(
   parameter int RATIO = 4
)(
   input wire logic clock,
   input wire logic in_ready,
   output logic src_ce,
   output logic dest_ce,
   output logic [15:0] din
);
   initial begin
      src_ce = 1'b0;
      dest_ce = 1'b0;
      din = 16'h0000;
   end

   // one frame of RATIO samples, frame end marked at end_slot, held while stalled
   task automatic send(input logic [7:0] f, input int end_slot);
      for (int s = 0; s < RATIO; s++) begin
         @(posedge clock);
         src_ce <= 1'b1;
         dest_ce <= (s == end_slot);
         din <= {f, 8'(s)};
         do @(negedge clock); while (in_ready !== 1'b1);
      end
      @(posedge clock);
      src_ce <= 1'b0;
      dest_ce <= 1'b0;
      din <= ~din;
   endtask
endmodule
